// *** hdl/position_report_framer.sv ***
// Position report framer: AXI4-Lite register file, frame builder, output FIFO
//
// Our own choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ns

module frame_fifo #(
  parameter int W = 9,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [AW:0] cnt;
    logic [W-1:0] odata;
    logic ovalid;
  } fifo_state_t;
  fifo_state_t s, n;
  logic push, pop;

  // Output stage is a register so the consumer sees flop-driven data
  assign in_ready = (s.cnt != DEPTH[AW:0]);
  assign out_data = s.odata;
  assign out_valid = s.ovalid;

  always_comb begin
    n = s;
    push = in_valid && in_ready;
    pop = (s.cnt != '0) && (!s.ovalid || out_ready);
    if (s.ovalid && out_ready) begin
      n.ovalid = 1'b0;
    end
    if (pop) begin
      n.odata = s.mem[s.rptr];
      n.ovalid = 1'b1;
      n.rptr = s.rptr + 1'b1;
    end
    if (push) begin
      n.mem[s.wptr] = in_data;
      n.wptr = s.wptr + 1'b1;
    end
    n.cnt = s.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s <= '0;
    end else if (ce) begin
      s <= n;
    end
  end
endmodule

module position_report_framer #(
  parameter int FIFO_W = 9,
  parameter int FIFO_D = framer_pkg::FIFO_DEPTH
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [7:0] tx_data,
  output logic tx_last,
  output logic tx_valid,
  input wire logic tx_ready
);
  framer_pkg::framer_state_t s, n;
  framer_pkg::frame_byte_t push_byte, out_byte;
  logic push_valid, push_ready, push_fire, busy, rtk;
  logic [7:0] last_idx, off, sv_off;
  logic [31:0] wmerged;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  assign busy = (s.state == framer_pkg::ST_SEND);
  assign rtk = s.pos_flags[6];
  assign last_idx = framer_pkg::IDX_LAST_BASE + {3'b000, s.sv_count, 1'b0};
  assign push_valid = busy;
  assign push_fire = push_valid && push_ready && ce;
  assign wmerged = merge(32'h0000_0000, s.wdata, s.wstrb);

  // Byte selected by the frame position
  always_comb begin
    off = s.idx - framer_pkg::IDX_FIELDS;
    sv_off = s.idx - framer_pkg::IDX_SV;
    push_byte.last = (s.idx == last_idx);
    push_byte.data = 8'h00;
    if (s.idx == 8'd0) begin
      push_byte.data = framer_pkg::START_BYTE;
    end else if (s.idx == 8'd1) begin
      push_byte.data = s.rx_status;
    end else if (s.idx == 8'd2) begin
      push_byte.data = framer_pkg::REPORT_TYPE;
    end else if (s.idx == 8'd3) begin
      // Whole record always fits one page, so no split is ever needed
      push_byte.data = framer_pkg::LEN_EXTRA + framer_pkg::RECORD_BASE_LEN
                       + {3'b000, s.sv_count, 1'b0};
    end else if (s.idx == framer_pkg::IDX_RECTYPE) begin
      push_byte.data = framer_pkg::RECORD_POSITION;
    end else if (s.idx == framer_pkg::IDX_PAGE) begin
      push_byte.data = framer_pkg::PAGE_ONE_OF_ONE;
    end else if (s.idx == framer_pkg::IDX_REPLY) begin
      push_byte.data = s.reply;
    end else if (s.idx < framer_pkg::IDX_TIME) begin
      // Doubles go out most significant word and byte first
      push_byte.data = s.fields[off[6:2]][8*(3 - off[1:0]) +: 8];
    end else if (s.idx < framer_pkg::IDX_FLAGS) begin
      push_byte.data = s.time_tag[8*(3 - off[1:0]) +: 8];
    end else if (s.idx == framer_pkg::IDX_FLAGS) begin
      push_byte.data = s.pos_flags;
    end else if (s.idx == framer_pkg::IDX_COUNT) begin
      push_byte.data = {4'h0, s.sv_count};
    end else if (s.idx < last_idx - 8'd2) begin
      if (!sv_off[0]) begin
        push_byte.data = rtk ? 8'h00 : s.sv_entry[sv_off[4:1]][15:8];
      end else begin
        push_byte.data = s.sv_entry[sv_off[4:1]][7:0];
      end
    end else if (s.idx == last_idx - 8'd2) begin
      push_byte.data = s.cksum[15:8];
    end else if (s.idx == last_idx - 8'd1) begin
      push_byte.data = s.cksum[7:0];
    end else begin
      push_byte.data = framer_pkg::END_BYTE;
    end
  end

  always_comb begin
    n = s;
    // Frame sequencer
    case (s.state)
      framer_pkg::ST_IDLE: begin
        n.idx = 8'd0;
      end
      framer_pkg::ST_SEND: begin
        if (push_valid && push_ready) begin
          n.idx = s.idx + 8'd1;
          if (s.idx != 8'd0 && s.idx < last_idx - 8'd2) begin
            n.cksum = s.cksum + {8'h00, push_byte.data};
          end
          if (push_byte.last) begin
            n.state = framer_pkg::ST_IDLE;
            n.reply = s.reply + 8'd1;
          end
        end
      end
      default: begin
        n.state = framer_pkg::ST_IDLE;
      end
    endcase
    // Write channel: address and data accepted in either order
    if (s.awready && s_axi_awvalid) begin
      n.aw_got = 1'b1;
      n.awaddr = s_axi_awaddr;
    end
    if (s.wready && s_axi_wvalid) begin
      n.w_got = 1'b1;
      n.wdata = s_axi_wdata;
      n.wstrb = s_axi_wstrb;
    end
    if (s.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    if (s.aw_got && s.w_got && !s.bvalid) begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = framer_pkg::RESP_OKAY;
      if (s.awaddr == framer_pkg::OFS_CTRL) begin
        if (s.wstrb[0]) begin
          n.enable = s.wdata[0];
          // Start only when enabled and idle; a request while busy is dropped
          if (s.wdata[1] && s.wdata[0] && !busy) begin
            n.state = framer_pkg::ST_SEND;
            n.cksum = 16'h0000;
          end
        end
      end else if (busy) begin
        // Record fields are frozen while a frame is being built
        n.bresp = framer_pkg::RESP_SLVERR;
      end else if (s.awaddr == framer_pkg::OFS_RX_STATUS) begin
        n.rx_status = s.wstrb[0] ? s.wdata[7:0] : s.rx_status;
      end else if (s.awaddr == framer_pkg::OFS_POS_FLAGS) begin
        n.pos_flags = s.wstrb[0] ? s.wdata[7:0] : s.pos_flags;
      end else if (s.awaddr == framer_pkg::OFS_SV_COUNT) begin
        if (s.wstrb[0] && s.wdata[7:0] > {4'h0, framer_pkg::MAX_SV}) begin
          n.bresp = framer_pkg::RESP_SLVERR;
        end else if (s.wstrb[0]) begin
          n.sv_count = s.wdata[3:0];
        end
      end else if (s.awaddr == framer_pkg::OFS_TIME_TAG) begin
        n.time_tag = merge(s.time_tag, s.wdata, s.wstrb);
      end else if (s.awaddr >= framer_pkg::OFS_FIELD_BASE
                   && s.awaddr <= framer_pkg::OFS_FIELD_LAST && s.awaddr[1:0] == 2'b00) begin
        n.fields[5'(8'(s.awaddr - framer_pkg::OFS_FIELD_BASE) >> 2)] =
          merge(s.fields[5'(8'(s.awaddr - framer_pkg::OFS_FIELD_BASE) >> 2)], s.wdata, s.wstrb);
      end else if (s.awaddr >= framer_pkg::OFS_SV_BASE
                   && s.awaddr <= framer_pkg::OFS_SV_LAST && s.awaddr[1:0] == 2'b00) begin
        if (wmerged[7:0] < framer_pkg::SAT_MIN || wmerged[7:0] > framer_pkg::SAT_MAX
            || s.wstrb[1:0] != 2'b11) begin
          n.bresp = framer_pkg::RESP_SLVERR;
        end else begin
          n.sv_entry[4'(8'(s.awaddr - framer_pkg::OFS_SV_BASE) >> 2)] = s.wdata[15:0];
        end
      end else begin
        n.bresp = framer_pkg::RESP_SLVERR;
      end
    end
    n.awready = !n.aw_got && !n.bvalid;
    n.wready = !n.w_got && !n.bvalid;
    // Read channel: answer one cycle after the address is taken
    if (s.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (s.arready && s_axi_arvalid) begin
      n.rvalid = 1'b1;
      n.rresp = framer_pkg::RESP_OKAY;
      n.rdata = 32'h0000_0000;
      if (s_axi_araddr == framer_pkg::OFS_CTRL) begin
        n.rdata = {31'h0, s.enable};
      end else if (s_axi_araddr == framer_pkg::OFS_STATUS) begin
        n.rdata = {16'h0, s.reply, 7'h0, busy};
      end else if (s_axi_araddr == framer_pkg::OFS_RX_STATUS) begin
        n.rdata = {24'h0, s.rx_status};
      end else if (s_axi_araddr == framer_pkg::OFS_POS_FLAGS) begin
        n.rdata = {24'h0, s.pos_flags};
      end else if (s_axi_araddr == framer_pkg::OFS_SV_COUNT) begin
        n.rdata = {28'h0, s.sv_count};
      end else if (s_axi_araddr == framer_pkg::OFS_TIME_TAG) begin
        n.rdata = s.time_tag;
      end else if (s_axi_araddr == framer_pkg::OFS_FLAG_VALID) begin
        n.rdata = {24'h0, framer_pkg::FLAG_VALID_VALUE};
      end else if (s_axi_araddr >= framer_pkg::OFS_FIELD_BASE
                   && s_axi_araddr <= framer_pkg::OFS_FIELD_LAST
                   && s_axi_araddr[1:0] == 2'b00) begin
        n.rdata = s.fields[5'(8'(s_axi_araddr - framer_pkg::OFS_FIELD_BASE) >> 2)];
      end else if (s_axi_araddr >= framer_pkg::OFS_SV_BASE
                   && s_axi_araddr <= framer_pkg::OFS_SV_LAST
                   && s_axi_araddr[1:0] == 2'b00) begin
        n.rdata = {16'h0, s.sv_entry[4'(8'(s_axi_araddr - framer_pkg::OFS_SV_BASE) >> 2)]};
      end else begin
        n.rresp = framer_pkg::RESP_SLVERR;
      end
    end
    n.arready = !n.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.state <= framer_pkg::ST_IDLE;
    end else if (ce) begin
      s <= n;
    end
  end

  // Back-pressure from the link stalls the sequencer through push_ready
  frame_fifo #(.W(FIFO_W), .DEPTH(FIFO_D)) u_fifo (
    .clk(aclk),
    .rst_n(aresetn),
    .ce(ce),
    .in_data(push_byte),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .out_data(out_byte),
    .out_valid(tx_valid),
    .out_ready(tx_ready)
  );

  assign tx_data = out_byte.data;
  assign tx_last = out_byte.last;
  assign s_axi_awready = s.awready;
  assign s_axi_wready = s.wready;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = s.arready;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence frame_end_s;
    push_fire && push_byte.last;
  endsequence

  AST_REPORT_TYPE: assert property (push_fire && s.idx == 8'd2 |-> push_byte.data == 8'h57)
    else $error("report type byte wrong");
  AST_FRAME_SIZE: assert property (frame_end_s |-> s.idx == 8'd87 + 8'(2 * s.sv_count))
    else $error("frame size wrong");
  AST_PAGING: assert property (push_fire && s.idx == 8'd5 |-> push_byte.data == 8'h11)
    else $error("paging byte wrong");
  AST_REPLY_STEP: assert property (frame_end_s ##1 ce |-> s.reply == $past(s.reply) + 8'd1)
    else $error("reply counter did not step once");
  AST_REPLY_HOLD: assert property (busy && !push_byte.last ##1 busy |-> $stable(s.reply))
    else $error("reply counter moved inside a report");
  AST_RECTYPE: assert property (push_fire && s.idx == 8'd4 |-> push_byte.data == 8'h01)
    else $error("record type wrong");
  AST_COUNT: assert property (push_fire && s.idx == 8'd84 |-> push_byte.data <= 8'h0C)
    else $error("satellite count out of range");
  AST_RTK_ZERO: assert property (push_fire && rtk && s.idx >= 8'd85 && s.idx < last_idx - 8'd2
                                 && !sv_off[0] |-> push_byte.data == 8'h00)
    else $error("channel not zero for kinematic solution");
  AST_SAT_RANGE: assert property (push_fire && s.idx >= 8'd85 && s.idx < last_idx - 8'd2
                                  && sv_off[0] |-> push_byte.data inside {[8'h01:8'h20]})
    else $error("satellite number out of range");
  AST_ENDS: assert property (push_fire && s.idx == 8'd0 |-> push_byte.data == 8'h02 ##0
                             (busy [*1] ##[1:1000] (frame_end_s and push_byte.data == 8'h03)))
    else $error("frame start or end byte wrong");
  AST_LENGTH: assert property (push_fire && s.idx == 8'd3 |->
                               push_byte.data == 8'd81 + 8'(2 * s.sv_count))
    else $error("length byte wrong");
endmodule

// *** hdl/framer_pkg.sv ***
// Constants, register map and state types for the position report framer
package framer_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_RX_STATUS = 8'h08;
  localparam logic [7:0] OFS_POS_FLAGS = 8'h0C;
  localparam logic [7:0] OFS_SV_COUNT = 8'h10;
  localparam logic [7:0] OFS_TIME_TAG = 8'h14;
  localparam logic [7:0] OFS_FLAG_VALID = 8'h18;
  localparam logic [7:0] OFS_FIELD_BASE = 8'h40;
  localparam logic [7:0] OFS_FIELD_LAST = 8'h84;
  localparam logic [7:0] OFS_SV_BASE = 8'hC0;
  localparam logic [7:0] OFS_SV_LAST = 8'hEC;
  // Frame constants
  localparam logic [7:0] START_BYTE = 8'h02;
  localparam logic [7:0] END_BYTE = 8'h03;
  localparam logic [7:0] REPORT_TYPE = 8'h57;
  localparam logic [7:0] RECORD_POSITION = 8'h01;
  localparam logic [7:0] PAGE_ONE_OF_ONE = 8'h11;
  localparam logic [7:0] FLAG_VALID_VALUE = 8'h01;
  localparam logic [7:0] RECORD_BASE_LEN = 8'd78;
  localparam logic [7:0] LEN_EXTRA = 8'd3;
  localparam logic [7:0] IDX_RECTYPE = 8'd4;
  localparam logic [7:0] IDX_PAGE = 8'd5;
  localparam logic [7:0] IDX_REPLY = 8'd6;
  localparam logic [7:0] IDX_FIELDS = 8'd7;
  localparam logic [7:0] IDX_TIME = 8'd79;
  localparam logic [7:0] IDX_FLAGS = 8'd83;
  localparam logic [7:0] IDX_COUNT = 8'd84;
  localparam logic [7:0] IDX_SV = 8'd85;
  localparam logic [7:0] IDX_LAST_BASE = 8'd87;
  localparam logic [3:0] MAX_SV = 4'd12;
  localparam logic [7:0] SAT_MIN = 8'h01;
  localparam logic [7:0] SAT_MAX = 8'h20;
  localparam int FIFO_DEPTH = 32;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_SEND = 2'b10} frame_state_t;

  typedef struct packed {
    logic [7:0] data;
    logic last;
  } frame_byte_t;

  typedef struct packed {
    frame_state_t state;
    logic [7:0] idx;
    logic [15:0] cksum;
    logic [7:0] reply;
    logic enable;
    logic [7:0] rx_status;
    logic [7:0] pos_flags;
    logic [3:0] sv_count;
    logic [31:0] time_tag;
    logic [17:0][31:0] fields;
    logic [11:0][15:0] sv_entry;
    logic aw_got;
    logic [7:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } framer_state_t;
endpackage

// *** dv/host_model.sv ***
// Remote host model: takes report bytes off the stream and keeps the last frame
`timescale 1ns/1ns

module host_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic slow,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  input wire logic tx_valid,
  output logic tx_ready,
  output int frames,
  output int last_at
);
  logic [7:0] frame_r [0:127];
  logic [7:0] reply_r;
  logic [2:0] ph_r;
  int cnt;

  // Slow mode takes one byte in eight, so the output FIFO fills and stalls
  always @(posedge aclk) begin
    if (!aresetn) begin
      tx_ready <= 1'b0;
      ph_r <= 3'h0;
      cnt <= 0;
      frames <= 0;
      last_at <= 0;
    end else begin
      ph_r <= ph_r + 3'h1;
      tx_ready <= slow ? (ph_r == 3'h7) : 1'b1;
      if (tx_valid && tx_ready) begin
        frame_r[cnt] <= tx_data;
        cnt <= cnt + 1;
        // Frames are single-page, so page one's counter is the reference
        if (cnt == 6) reply_r <= tx_data;
        if (tx_last) begin
          frames <= frames + 1;
          last_at <= cnt;
          cnt <= 0;
        end
      end
    end
  end
endmodule

// *** dv/tb_top.sv ***
// Testbench: register access over AXI4-Lite and report frame checks
`timescale 1ns/1ns

module tb_top;
  logic aclk, aresetn, ce, slow;
  logic [7:0] awaddr, araddr, tx_data;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, tx_last, tx_valid, tx_ready;
  logic [1:0] bresp, rresp;
  logic [7:0] ex [0:127];
  int frames, last_at, num_errors, compares, cyc;
  int nsv [3] = '{12, 12, 0};
  logic [7:0] flv [3] = '{8'h04, 8'h44, 8'h01};

  position_report_framer dut_u (
    .aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .tx_data(tx_data),
    .tx_last(tx_last), .tx_valid(tx_valid), .tx_ready(tx_ready)
  );

  host_model host_u (
    .aclk(aclk), .aresetn(aresetn), .slow(slow), .tx_data(tx_data),
    .tx_last(tx_last), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .frames(frames), .last_at(last_at)
  );

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  task automatic close_out();
    $display("errors=%0d compares=%0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Bound sized from three frames plus register traffic
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      num_errors++;
      close_out();
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
      output logic [1:0] r);
    r = 2'b11;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int t = 0; t < 200; t++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic wx(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [1:0] r;
    axw(a, d, 4'hF, r);
    chk({30'h0, r}, {30'h0, er});
  endtask

  task automatic rx(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    d = '1;
    r = 2'b11;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int t = 0; t < 200; t++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
    chk(d, ed);
    chk({30'h0, r}, {30'h0, er});
  endtask

  task automatic frame(input int n, input logic [7:0] fl, input logic [7:0] rep);
    logic [31:0] v;
    logic [15:0] ck;
    logic [7:0] sat;
    int f0;
    ex[0] = 8'h02;
    ex[1] = 8'h30 + rep;
    ex[2] = 8'h57;
    ex[3] = 8'(81 + 2 * n);
    ex[4] = 8'h01;
    ex[5] = 8'h11;
    ex[6] = rep;
    wx(framer_pkg::OFS_RX_STATUS, {24'h0, ex[1]}, framer_pkg::RESP_OKAY);
    wx(framer_pkg::OFS_POS_FLAGS, {24'h0, fl}, framer_pkg::RESP_OKAY);
    wx(framer_pkg::OFS_SV_COUNT, 32'(n), framer_pkg::RESP_OKAY);
    v = {rep, 24'h654321};
    wx(framer_pkg::OFS_TIME_TAG, v, framer_pkg::RESP_OKAY);
    for (int b = 0; b < 4; b++) ex[79 + b] = v[31 - 8 * b -: 8];
    for (int i = 0; i < 18; i++) begin
      v = 32'h11223344 + 32'(i) * 32'h01010101 + 32'(rep);
      wx(8'(framer_pkg::OFS_FIELD_BASE + 4 * i), v, framer_pkg::RESP_OKAY);
      for (int b = 0; b < 4; b++) ex[7 + 4 * i + b] = v[31 - 8 * b -: 8];
    end
    ex[83] = fl;
    ex[84] = 8'(n);
    for (int j = 0; j < 12; j++) begin
      sat = (j == 11) ? 8'h20 : 8'(j + 1);
      wx(8'(framer_pkg::OFS_SV_BASE + 4 * j), {16'h0, 8'(j + 3), sat},
         framer_pkg::RESP_OKAY);
      ex[85 + 2 * j] = fl[6] ? 8'h00 : 8'(j + 3);
      ex[86 + 2 * j] = sat;
    end
    ck = 16'h0;
    for (int i = 1; i <= 84 + 2 * n; i++) ck = ck + {8'h0, ex[i]};
    ex[85 + 2 * n] = ck[15:8];
    ex[86 + 2 * n] = ck[7:0];
    ex[87 + 2 * n] = 8'h03;
    f0 = frames;
    wx(framer_pkg::OFS_CTRL, 32'h3, framer_pkg::RESP_OKAY);
    if (slow) begin
      rx(framer_pkg::OFS_STATUS, {16'h0, rep, 8'h01}, framer_pkg::RESP_OKAY);
      // Record fields stay frozen while a report is being built
      wx(framer_pkg::OFS_RX_STATUS, 32'h5A, framer_pkg::RESP_SLVERR);
      wx(framer_pkg::OFS_CTRL, 32'h3, framer_pkg::RESP_OKAY);
    end
    for (int t = 0; t < 5000 && frames == f0; t++) @(posedge aclk);
    repeat (200) @(posedge aclk);
    chk(32'(frames), 32'(f0 + 1));
    chk(32'(last_at), 32'(87 + 2 * n));
    chk({24'h0, host_u.reply_r}, {24'h0, rep});
    for (int i = 0; i <= 87 + 2 * n; i++)
      chk({24'h0, host_u.frame_r[i]}, {24'h0, ex[i]});
    rx(framer_pkg::OFS_STATUS, {16'h0, rep + 8'h01, 8'h00}, framer_pkg::RESP_OKAY);
  endtask

  initial begin
    logic [1:0] r;
    {ce, slow, awvalid, wvalid, bready, arvalid, rready} = 7'h40;
    {awaddr, araddr, wdata, wstrb} = '0;
    aresetn = 1'b0;
    num_errors = 0;
    compares = 0;
    cyc = 0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rx(framer_pkg::OFS_STATUS, 32'h0, framer_pkg::RESP_OKAY);
    rx(framer_pkg::OFS_FLAG_VALID, 32'h1, framer_pkg::RESP_OKAY);
    rx(8'h30, 32'h0, framer_pkg::RESP_SLVERR);
    wx(8'h34, 32'h1, framer_pkg::RESP_SLVERR);
    wx(framer_pkg::OFS_SV_COUNT, 32'hD, framer_pkg::RESP_SLVERR);
    rx(framer_pkg::OFS_SV_COUNT, 32'h0, framer_pkg::RESP_OKAY);
    wx(framer_pkg::OFS_SV_BASE, 32'h0121, framer_pkg::RESP_SLVERR);
    wx(framer_pkg::OFS_SV_BASE, 32'h0100, framer_pkg::RESP_SLVERR);
    axw(framer_pkg::OFS_SV_BASE, 32'h0105, 4'h1, r);
    chk({30'h0, r}, {30'h0, framer_pkg::RESP_SLVERR});
    // Start without the record enabled must not emit anything
    wx(framer_pkg::OFS_CTRL, 32'h2, framer_pkg::RESP_OKAY);
    repeat (100) @(posedge aclk);
    chk(32'(frames), 32'h0);
    rx(framer_pkg::OFS_CTRL, 32'h0, framer_pkg::RESP_OKAY);
    for (int k = 0; k < 3; k++) begin
      slow <= (k == 0);
      frame(nsv[k], flv[k], 8'(k));
    end
    rx(framer_pkg::OFS_CTRL, 32'h1, framer_pkg::RESP_OKAY);
    close_out();
  end
endmodule
